/* File: hdl/rss_top.sv */
`timescale 1ns/1ps
`include "rss_map.svh"

module rss_top #(
   parameter int IRQ_N = 8
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              reset_pin_n,
   input  wire logic              power_on_clear,
   input  wire logic              low_voltage_detector,
   input  wire logic              wdt_overflow,
   input  wire logic [1:0]        opt_osc_wait,
   input  wire logic              opt_pin_as_port,
   input  wire logic              opt_reload_done,
   input  wire logic              osc_is_resonator,
   input  wire logic [IRQ_N-1:0]  irq_req,
   input  wire logic [IRQ_N-1:0]  irq_mask,
   output logic                   cpu_reset_n,
   output logic                   periph_reset_n,
   output logic                   lvd_reset_n,
   output logic                   cpu_halt,
   output logic                   sys_osc_en,
   output logic                   ls_osc_en,
   output logic                   shared_input_port_pin
);

   localparam logic [15:0] SETTLE_CYC = 16'(`RSS_SETTLE_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic               pin_s;
   logic [2:0]         int_s;
   rss_pkg::rss_src_t  src;

   rss_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b1)
   ) u_sync_pin (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (reset_pin_n),
      .q     (pin_s)
   );

   rss_sync #(
      .WIDTH   (3),
      .RST_VAL (3'h0)
   ) u_sync_int (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({wdt_overflow, low_voltage_detector, power_on_clear}),
      .q     (int_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Reset merge
   logic port_win_q;
   logic port_win_d;
   logic pin_low;
   logic int_any;
   logic rst_any;
   logic rst_no_lvd;

   assign pin_low    = ~pin_s;
   assign int_any    = |int_s;
   // Port window opens on internal reset
   assign port_win_d = int_any ? 1'b1 :
                       (opt_reload_done && !pin_low) ? 1'b0 : port_win_q;
   // Pin reset follows the low level unless the pin is a port and its window is closed
   assign src.pin    = pin_low & (~opt_pin_as_port | port_win_q);
   assign src.por    = int_s[0];
   assign src.lvd    = int_s[1];
   assign src.wdt    = int_s[2];
   assign rst_any    = src.pin | src.por | src.lvd | src.wdt;
   // Detector excluded from its own reset
   assign rst_no_lvd = src.pin | src.por | src.wdt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_win_q <= 1'b1;
      end else begin
         port_win_q <= port_win_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   logic        wr_en;
   logic        acc;
   logic        hit_ctrl;
   logic        hit_sel;
   logic        hit_stat;
   logic        hit_any;
   logic        idle_wr;
   logic        stop_wr;
   logic        cause_clr_wr;
   logic [1:0]  osc_sel_q;
   logic [1:0]  osc_sel_d;
   logic [3:0]  cause_q;
   logic [3:0]  cause_d;
   logic [3:0]  cause_clr;
   logic [31:0] rdata;
   rss_pkg::rss_state_t state_q;
   rss_pkg::rss_state_t state_d;

   assign acc          = psel & penable & pready;
   assign wr_en        = acc & pwrite;
   assign hit_ctrl     = paddr == `RSS_OFF_CTRL;
   assign hit_sel      = paddr == `RSS_OFF_OSC_SEL;
   assign hit_stat     = paddr == `RSS_OFF_STATUS;
   assign hit_any      = hit_ctrl | hit_sel | hit_stat;
   assign idle_wr      = wr_en & hit_ctrl & pwdata[`RSS_CTRL_IDLE];
   assign stop_wr      = wr_en & hit_ctrl & pwdata[`RSS_CTRL_STOP];
   assign cause_clr_wr = wr_en & hit_stat;
   assign cause_clr    = cause_clr_wr ?
                         pwdata[`RSS_STAT_CAUSE +: 4] : 4'h0;
   assign osc_sel_d    = (wr_en && hit_sel) ? pwdata[1:0] : osc_sel_q;
   // Set wins over clear
   assign cause_d      = (cause_q & ~cause_clr) | src;
   assign rdata        = hit_sel  ? {30'h0, osc_sel_q} :
                         hit_stat ? {20'h0, cause_q, 3'h0,
                                     opt_pin_as_port, pin_s,
                                     3'(state_q)} :
                         32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         prdata    <= 32'h0;
         osc_sel_q <= `RSS_OSC_SEL_RST;
         cause_q   <= 4'h0;
      end else begin
         pready    <= psel & ~penable;
         pslverr   <= psel & ~penable & ~hit_any;
         prdata    <= (psel && !penable && !pwrite) ? rdata : 32'h0;
         osc_sel_q <= osc_sel_d;
         cause_q   <= cause_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Standby sequencer
   logic        wake;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] opt_cnt;
   logic [15:0] xtal_cnt;
   logic        cnt_zero;

   assign wake     = |(irq_req & ~irq_mask);
   assign cnt_zero = cnt_q == 16'h0;
   assign opt_cnt  = (opt_osc_wait == 2'h0) ? `RSS_OPT_WAIT0 :
                     (opt_osc_wait == 2'h1) ? `RSS_OPT_WAIT1 :
                     (opt_osc_wait == 2'h2) ? `RSS_OPT_WAIT2 :
                                              `RSS_OPT_WAIT3;
   assign xtal_cnt = (osc_sel_q == 2'h0) ? `RSS_OSC_WAIT0 :
                     (osc_sel_q == 2'h1) ? `RSS_OSC_WAIT1 :
                     (osc_sel_q == 2'h2) ? `RSS_OSC_WAIT2 :
                                           `RSS_OSC_WAIT3;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_zero ? 16'h0 : cnt_q - 16'h1;
      unique case (state_q)
         rss_pkg::ST_RESET: begin
            cnt_d = 16'h0;
            if (!rst_any) begin
               state_d = rss_pkg::ST_OPT_WAIT;
               cnt_d   = opt_cnt;
            end
         end
         rss_pkg::ST_OPT_WAIT: begin
            if (cnt_zero) begin
               state_d = rss_pkg::ST_RUN;
            end
         end
         rss_pkg::ST_RUN: begin
            if (stop_wr && !wake) begin
               state_d = rss_pkg::ST_STOP;
            end else if (idle_wr && !wake) begin
               state_d = rss_pkg::ST_IDLE;
            end
         end
         rss_pkg::ST_IDLE: begin
            if (wake) begin
               state_d = rss_pkg::ST_RUN;
            end
         end
         rss_pkg::ST_STOP: begin
            if (wake) begin
               state_d = rss_pkg::ST_SETTLE;
               cnt_d   = SETTLE_CYC - 16'h1;
            end
         end
         rss_pkg::ST_SETTLE: begin
            if (cnt_zero) begin
               if (osc_is_resonator) begin
                  state_d = rss_pkg::ST_XTAL_WAIT;
                  cnt_d   = xtal_cnt;
               end else begin
                  state_d = rss_pkg::ST_RUN;
               end
            end
         end
         rss_pkg::ST_XTAL_WAIT: begin
            if (cnt_zero) begin
               state_d = rss_pkg::ST_RUN;
            end
         end
      endcase
      if (rst_any) begin
         state_d = rss_pkg::ST_RESET;
         cnt_d   = 16'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= rss_pkg::ST_RESET;
         cnt_q   <= 16'h0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   logic halt_d;
   logic sys_osc_d;

   assign halt_d    = state_d == rss_pkg::ST_IDLE ||
                      state_d == rss_pkg::ST_STOP ||
                      state_d == rss_pkg::ST_SETTLE ||
                      state_d == rss_pkg::ST_XTAL_WAIT;
   assign sys_osc_d = state_d != rss_pkg::ST_RESET &&
                      state_d != rss_pkg::ST_STOP;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_reset_n           <= 1'b0;
         periph_reset_n        <= 1'b0;
         lvd_reset_n           <= 1'b0;
         cpu_halt              <= 1'b0;
         sys_osc_en            <= 1'b0;
         ls_osc_en             <= 1'b0;
         shared_input_port_pin <= 1'b1;
      end else begin
         cpu_reset_n           <= state_d != rss_pkg::ST_RESET &&
                                  state_d != rss_pkg::ST_OPT_WAIT;
         periph_reset_n        <= ~rst_any;
         lvd_reset_n           <= ~rst_no_lvd;
         cpu_halt              <= halt_d;
         sys_osc_en            <= sys_osc_d;
         ls_osc_en             <= ~rst_any;
         shared_input_port_pin <= pin_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_stop_wake;
      state_q == rss_pkg::ST_STOP && wake && !rst_any;
   endsequence

   sequence s_settle_done;
      state_q == rss_pkg::ST_SETTLE && cnt_zero && !rst_any;
   endsequence

   a_opt_wait_load: assert property (
      state_q == rss_pkg::ST_RESET && !rst_any |=>
      state_q == rss_pkg::ST_OPT_WAIT && cnt_q == $past(opt_cnt))
      else $error("reset wait not taken from option byte");

   a_idle_cancel: assert property (
      state_q == rss_pkg::ST_RUN && idle_wr && wake && !rst_any |=>
      state_q == rss_pkg::ST_RUN && !cpu_halt)
      else $error("idle entered with pending interrupt");

   a_stop_cancel: assert property (
      state_q == rss_pkg::ST_RUN && stop_wr && wake && !rst_any |=>
      state_q == rss_pkg::ST_RUN && sys_osc_en)
      else $error("stop entered with pending interrupt");

   a_settle_len: assert property (
      s_stop_wake |=> state_q == rss_pkg::ST_SETTLE &&
      cnt_q == SETTLE_CYC - 16'h1 && cpu_halt)
      else $error("settle interval wrong");

   a_xtal_add: assert property (
      s_settle_done and osc_is_resonator |=>
      state_q == rss_pkg::ST_XTAL_WAIT && cnt_q == $past(xtal_cnt))
      else $error("resonator wait not added");

   a_osc_stop_rst: assert property (
      rst_any |=> !sys_osc_en && !ls_osc_en)
      else $error("oscillator running during reset");

   a_port_reset: assert property (
      opt_pin_as_port && port_win_q && pin_low |=>
      state_q == rss_pkg::ST_RESET && !cpu_reset_n)
      else $error("shared pin low did not reset");

   a_port_hold: assert property (
      opt_pin_as_port && src.pin |=>
      state_q == rss_pkg::ST_RESET && !periph_reset_n)
      else $error("reset released while pin low");

   a_lvd_keep: assert property (
      src.lvd && !rst_no_lvd |=> lvd_reset_n && !periph_reset_n)
      else $error("detector reset itself");

   a_wdt_self: assert property (
      src.wdt |=> !periph_reset_n ##1 !cpu_reset_n)
      else $error("watchdog not reset by own overflow");

   a_rst_merge: assert property (
      $fell(rst_any) |-> ##1 periph_reset_n && !cpu_reset_n)
      else $error("merged reset release wrong");

endmodule : rss_top

/* File: hdl/rss_map.svh */
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

////////////////////////////////////////////////////////////////////////////
// Register offsets
`define RSS_OFF_CTRL      8'h00
`define RSS_OFF_OSC_SEL   8'h04
`define RSS_OFF_STATUS    8'h08

////////////////////////////////////////////////////////////////////////////
// Field positions and select reset value
`define RSS_CTRL_IDLE     0
`define RSS_CTRL_STOP     1
`define RSS_STAT_PIN      3
`define RSS_STAT_PORT     4
`define RSS_STAT_CAUSE    8
`define RSS_OSC_SEL_RST   2'h0

////////////////////////////////////////////////////////////////////////////
// Timing
`define RSS_CLK_NS        25
`define RSS_SETTLE_NS     34000
`define RSS_SETTLE_CYC    ((`RSS_SETTLE_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_PIN_MIN_NS    2000

// Option byte wait after reset, cycles
`define RSS_OPT_WAIT0     16'h0100
`define RSS_OPT_WAIT1     16'h0200
`define RSS_OPT_WAIT2     16'h0400
`define RSS_OPT_WAIT3     16'h0800

// Select register wait after stop, cycles
`define RSS_OSC_WAIT0     16'h0080
`define RSS_OSC_WAIT1     16'h0100
`define RSS_OSC_WAIT2     16'h0200
`define RSS_OSC_WAIT3     16'h0400

`endif

/* File: hdl/rss_pkg.sv */
package rss_pkg;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_OPT_WAIT,
      ST_RUN,
      ST_IDLE,
      ST_STOP,
      ST_SETTLE,
      ST_XTAL_WAIT
   } rss_state_t;

   typedef struct packed {
      logic pin;
      logic wdt;
      logic lvd;
      logic por;
   } rss_src_t;

endpackage : rss_pkg

/* File: hdl/rss_sync.sv */
`timescale 1ns/1ps

module rss_sync #(
   parameter int           WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : rss_sync

/* File: bench/rss_partner.sv */
`timescale 1ns/1ps

module rss_partner #(
   parameter int IRQ_N   = 8,
   parameter int PIN_MIN = 80
) (
   input  wire logic        pclk,
   output logic             reset_pin_n,
   output logic [IRQ_N-1:0] irq_req,
   output logic [IRQ_N-1:0] irq_mask
);
   initial begin
      reset_pin_n = 1'b1;
      irq_req     = '0;
      irq_mask    = '0;
   end

   task automatic hold_pin(input int cyc);
      int n;
      n = (cyc < PIN_MIN) ? PIN_MIN : cyc;
      @(posedge pclk);
      reset_pin_n <= 1'b0;
      repeat (n) @(posedge pclk);
      reset_pin_n <= 1'b1;
   endtask : hold_pin

   // Slow or prompt request
   task automatic raise_irq(input int idx, input int dly);
      repeat (dly) @(posedge pclk);
      irq_req[idx] <= 1'b1;
   endtask : raise_irq

   task automatic set_mask(input logic [IRQ_N-1:0] m);
      @(posedge pclk);
      irq_mask <= m;
   endtask : set_mask

   task automatic clear_irq();
      @(posedge pclk);
      irq_req <= '0;
   endtask : clear_irq
endmodule : rss_partner

/* File: bench/rss_top_tb.sv */
`timescale 1ns/1ps
`include "rss_map.svh"

module rss_top_tb;
   localparam int IRQ_N = 8;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata;
   logic             reset_pin_n, power_on_clear, low_voltage_detector;
   logic             wdt_overflow, opt_pin_as_port, opt_reload_done;
   logic             osc_is_resonator, cpu_reset_n, periph_reset_n;
   logic             lvd_reset_n, cpu_halt, sys_osc_en, ls_osc_en, port_pin;
   logic [1:0]       opt_osc_wait;
   logic [IRQ_N-1:0] irq_req, irq_mask;
   logic [32:0]      exp_q[$];
   int               mismatches, compares, cyc;

   rss_top #(.IRQ_N(IRQ_N)) rss_top_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reset_pin_n(reset_pin_n), .power_on_clear(power_on_clear),
      .low_voltage_detector(low_voltage_detector),
      .wdt_overflow(wdt_overflow), .opt_osc_wait(opt_osc_wait),
      .opt_pin_as_port(opt_pin_as_port), .opt_reload_done(opt_reload_done),
      .osc_is_resonator(osc_is_resonator), .irq_req(irq_req),
      .irq_mask(irq_mask), .cpu_reset_n(cpu_reset_n),
      .periph_reset_n(periph_reset_n), .lvd_reset_n(lvd_reset_n),
      .cpu_halt(cpu_halt), .sys_osc_en(sys_osc_en), .ls_osc_en(ls_osc_en),
      .shared_input_port_pin(port_pin));

   rss_partner #(.IRQ_N(IRQ_N), .PIN_MIN(`RSS_PIN_MIN_NS / `RSS_CLK_NS))
      rss_partner_i (.pclk(pclk), .reset_pin_n(reset_pin_n),
      .irq_req(irq_req), .irq_mask(irq_mask));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the bench timeout ends this
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic wait_run(output int n);
      n = 0;
      while (cpu_reset_n !== 1'b1 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      check(33'(n < 5000), 33'h1);
   endtask : wait_run

   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
         check({pslverr, prdata}, exp_q.pop_front());
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 80000) begin
         mismatches++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      int         n, w;
      logic [1:0] s;
      void'($urandom(32'hc22cf591));
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {power_on_clear, low_voltage_detector, wdt_overflow} = '0;
      {opt_pin_as_port, opt_reload_done, osc_is_resonator} = '0;
      presetn      = 1'b0;
      opt_osc_wait = 2'($urandom % 4);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      wait_run(n);
      w = 256 << opt_osc_wait;
      check(33'(n >= w - 2 && n <= w + 4), 33'h1);
      rd(`RSS_OFF_OSC_SEL, 33'h0);
      rd(8'h40, 33'h1_0000_0000);
      rd(`RSS_OFF_STATUS, 33'h0a);
      rss_partner_i.raise_irq(3, 1);
      apb(1'b1, `RSS_OFF_CTRL, 32'h1);
      repeat (3) @(posedge pclk);
      check(33'(cpu_halt), 33'h0);
      apb(1'b1, `RSS_OFF_CTRL, 32'h2);
      repeat (3) @(posedge pclk);
      check(33'({cpu_halt, sys_osc_en}), 33'h1);
      rd(`RSS_OFF_STATUS, 33'h0a);
      rss_partner_i.set_mask('1);
      apb(1'b1, `RSS_OFF_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      check(33'(cpu_halt), 33'h1);
      rss_partner_i.set_mask('0);
      repeat (3) @(posedge pclk);
      check(33'(cpu_halt), 33'h0);
      rss_partner_i.clear_irq();
      for (int i = 0; i < 5; i++) begin
         s = 2'($urandom % 4);
         osc_is_resonator <= (i > 0);
         apb(1'b1, `RSS_OFF_OSC_SEL, {30'h0, s});
         rd(`RSS_OFF_OSC_SEL, {31'h0, s});
         apb(1'b1, `RSS_OFF_CTRL, 32'h2);
         repeat (2) @(posedge pclk);
         check(33'({cpu_halt, sys_osc_en}), 33'h2);
         w = 34000 / 25 + ((i > 0) ? (128 << s) : 0);
         rss_partner_i.raise_irq($urandom % IRQ_N, 1 + $urandom % 20);
         n = 0;
         while (cpu_halt !== 1'b0 && n < 5000) begin
            @(posedge pclk);
            n++;
         end
         check(33'(n >= w && n <= w + 4), 33'h1);
         rss_partner_i.clear_irq();
      end
      wdt_overflow <= 1'b1;
      repeat (6) @(posedge pclk);
      check(33'({periph_reset_n, lvd_reset_n, ls_osc_en, sys_osc_en}),
            33'h0);
      wdt_overflow <= 1'b0;
      wait_run(n);
      // Sticky watchdog cause, then write one to clear
      rd(`RSS_OFF_STATUS, 33'h40a);
      apb(1'b1, `RSS_OFF_STATUS, 32'h0000_0f00);
      rd(`RSS_OFF_STATUS, 33'h0a);
      low_voltage_detector <= 1'b1;
      repeat (6) @(posedge pclk);
      check(33'({periph_reset_n, lvd_reset_n, ls_osc_en}), 33'h2);
      low_voltage_detector <= 1'b0;
      wait_run(n);
      rss_partner_i.hold_pin(100);
      check(33'(cpu_reset_n), 33'h0);
      wait_run(n);
      opt_pin_as_port <= 1'b1;
      wdt_overflow    <= 1'b1;
      repeat (6) @(posedge pclk);
      wdt_overflow <= 1'b0;
      wait_run(n);
      rss_partner_i.hold_pin(300);
      check(33'({cpu_reset_n, port_pin}), 33'h0);
      wait_run(n);
      opt_reload_done <= 1'b1;
      @(posedge pclk);
      opt_reload_done <= 1'b0;
      rss_partner_i.hold_pin(100);
      check(33'(cpu_reset_n), 33'h1);
      close_out();
   end
endmodule : rss_top_tb
